// *** flash_prog_pkg.sv ***
package flash_prog_pkg;
  // command opcodes
  localparam logic [7:0] OP_WRITE_ENABLE_CMD   = 8'h10;
  localparam logic [7:0] OP_PP     = 8'h11;
  localparam logic [7:0] OP_QPP    = 8'h12;
  localparam logic [7:0] OP_DP     = 8'h13;
  localparam logic [7:0] OP_RDP    = 8'h14;
  localparam logic [7:0] OP_SECWR  = 8'h15;
  localparam logic [7:0] OP_SECRD  = 8'h16;
  localparam logic [7:0] OP_OTPIN  = 8'h17;
  localparam logic [7:0] OP_OTPOUT = 8'h18;
  // frame byte counts: opcode, opcode plus address, first data byte
  localparam logic [2:0] TOT_OP    = 3'h1;
  localparam logic [2:0] TOT_ADDR  = 3'h4;
  localparam logic [2:0] TOT_DATA  = 3'h5;
  localparam int         PAGE_BYTES = 256;
  // security register bit positions
  localparam int SEC_PSEL  = 7;
  localparam int SEC_PFAIL = 5;
  localparam int SEC_LOCK  = 1;
  localparam int SEC_FACT  = 0;
  // core clock and default times
  localparam int CLK_PERIOD_NS   = 10;
  localparam int PROG_TIME_US    = 500;
  localparam int SLEEP_DELAY_US  = 10;
endpackage

// *** serial_flash_prog_ctrl.sv ***
// What this block does
// - page program needs the write-enable latch set, else it is refused
// - only the last 256 data bytes of a program frame are written
// - data past page end wraps to page start, upper address kept
// - bytes not sent leave the rest of the page unaltered
// - select must rise on a data byte boundary or nothing is programmed
// - program cycle starts at select rise; busy flag set, then clears with latch
// - protected target page by selected scheme skips the program
// - opcode is eight clocks single-line or two clocks four-line
// - quad page program needs latch, quad-enable and single-line mode; address and data on four lines
// - quad program to a protected page leaves the array untouched
// - deep sleep is opcode only, select rising at the byte boundary
// - deep sleep entered a fixed delay after select rises
// - in deep sleep every opcode except release is ignored
// - release command or reset returns to standby
// - security write needs latch, sets lock-down bit; locked area frozen
// - security write is opcode only, select rising at the byte boundary
// - security read works any time except in deep sleep, repeats register until select rises
// - enter-otp makes program commands address the otp area
// - locked otp mode refuses any program
// - exit-otp returns to main array addressing
// - program-fail flag set on failure or protection, cleared on success
// - protection select picks block-protect or solid-protection scheme
`timescale 1ns/100ps
`default_nettype none
module serial_flash_prog_ctrl
  import flash_prog_pkg::*;
#(
  parameter int          PROG_US      = PROG_TIME_US,
  parameter int          SLEEP_US     = SLEEP_DELAY_US,
  parameter logic        FACTORY_LOCK = 1'b0  // value arbitrary
) (
  // core clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESET_N_I,
  // serial link
  input  wire logic        LINK_CLK_I,
  input  wire logic        CS_N_I,
  input  wire logic [3:0]  QIO_I,
  output logic      [3:0]  QIO_O,
  output logic      [3:0]  QIO_OE_O,
  // configuration from neighbouring logic, core clock
  input  wire logic        QUAD_MODE_I,
  input  wire logic        QUAD_ENABLE_I,
  input  wire logic        PROT_SELECT_I,
  input  wire logic        BP_PROT_I,
  input  wire logic        SOLID_PROT_I,
  // status
  output logic             WIP_O,
  output logic             WEL_O,
  output logic             PROG_FAIL_O,
  output logic             LOCKDOWN_O,
  output logic             OTP_MODE_O,
  output logic             SLEEP_O,
  // array write port and protection lookup
  output logic [15:0]      PAGE_ADDR_O,
  output logic             ARR_WE_O,
  output logic             ARR_OTP_O,
  output logic [23:0]      ARR_ADDR_O,
  output logic [7:0]       ARR_DATA_O
);
  localparam int PROG_CYC = (PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLP_CYC  = (SLEEP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [23:0] PROG_LAST = 24'(PROG_CYC - 1);
  localparam logic [23:0] SLP_LAST  = 24'(SLP_CYC - 1);

  if (PROG_CYC < PAGE_BYTES + 4 || SLP_CYC < 1 || PROG_CYC > 24'hffffff) begin : g_chk
    $error("program time too short for a page walk or counts out of range");
  end

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_CHECK = 6'b000010,
    ST_WRITE = 6'b000100,
    ST_WAIT  = 6'b001000,
    ST_NAP   = 6'b010000,
    ST_SLEEP = 6'b100000
  } st_t;

  // ---------------- link domain ----------------
  logic              act_r;
  logic [2:0]        bits_r;
  logic [7:0]        sh_r;
  logic [7:0]        lop_r;
  logic [23:0]       laddr_r;
  logic [2:0]        ltot_r;
  logic              lalign_r;
  logic [7:0]        didx_r;
  logic [255:0]      lmask_r;
  logic [7:0]        lbuf [PAGE_BYTES];
  logic [9:0]        lsm_r;
  logic [9:0]        lss_r;
  logic [3:0]        qo_r;
  logic [3:0]        qoe_r;
  logic [2:0]        cur_bits;
  logic [2:0]        cur_tot;
  logic              wide;
  logic [7:0]        sh_nxt;
  logic [3:0]        sum;
  logic              byte_done;
  logic              data_byte;
  logic [7:0]        lsec;
  logic              sleep_r;
  logic [7:0]        sec_r;

  // synchronised core levels: four-line mode, sleep, security register
  always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lsm_r <= 10'h000;
      lss_r <= 10'h000;
    end else begin
      lsm_r <= {QUAD_MODE_I, sleep_r, sec_r};
      lss_r <= lsm_r;
    end
  end
  assign lsec = lss_r[7:0];

  always_comb begin
    cur_bits  = act_r ? bits_r : 3'h0;
    cur_tot   = act_r ? ltot_r : 3'h0;
    wide      = lss_r[9] || (cur_tot != 3'h0 && lop_r == OP_QPP);
    sh_nxt    = wide ? {sh_r[3:0], QIO_I} : {sh_r[6:0], QIO_I[0]};
    sum       = {1'b0, cur_bits} + (wide ? 4'h4 : 4'h1);
    byte_done = sum[3];
    data_byte = byte_done && cur_tot >= TOT_ADDR;
  end

  // frame-local counters cleared while select is high
  always_ff @(posedge LINK_CLK_I or posedge CS_N_I or negedge RESET_N_I) begin
    if (!RESET_N_I || CS_N_I) begin
      act_r  <= 1'b0;
      bits_r <= 3'h0;
    end else begin
      act_r  <= 1'b1;
      bits_r <= sum[2:0];
    end
  end

  // frame summary survives select rise for the core to read
  always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      sh_r     <= 8'h00;
      lop_r    <= 8'h00;
      laddr_r  <= 24'h000000;
      ltot_r   <= 3'h0;
      lalign_r <= 1'b0;
      didx_r   <= 8'h00;
    end else begin
      sh_r     <= sh_nxt;
      lalign_r <= byte_done;
      ltot_r   <= (byte_done && cur_tot != TOT_DATA) ? cur_tot + 3'h1 : cur_tot;
      if (byte_done && cur_tot == 3'h0) begin
        lop_r <= sh_nxt;
      end
      if (byte_done && cur_tot != 3'h0 && cur_tot < TOT_ADDR) begin
        laddr_r <= {laddr_r[15:0], sh_nxt};
      end
      if (byte_done && cur_tot == TOT_ADDR - 3'h1) begin
        didx_r <= sh_nxt;
      end else if (data_byte) begin
        didx_r <= didx_r + 8'h01;
      end
    end
  end

  // later bytes overwrite earlier ones at the wrapped column
  // cleared only when a frame completes its third address byte, so a status read of at most two register bytes during the walk keeps it;
  // a frame carrying data while busy would still disturb the walk
  always_ff @(posedge LINK_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      lmask_r <= '0;
    end else if (byte_done && cur_tot == TOT_ADDR - 3'h1) begin
      lmask_r <= '0;
    end else if (data_byte) begin
      lmask_r[didx_r] <= 1'b1;
    end
  end

  always_ff @(posedge LINK_CLK_I) begin
    if (data_byte) begin
      lbuf[didx_r] <= sh_nxt;
    end
  end

  // security register read, launched on the falling edge
  always_ff @(negedge LINK_CLK_I or posedge CS_N_I or negedge RESET_N_I) begin
    if (!RESET_N_I || CS_N_I) begin
      qo_r  <= 4'h0;
      qoe_r <= 4'h0;
    end else if (act_r && ltot_r != 3'h0 && lop_r == OP_SECRD && !lss_r[8]) begin
      if (lss_r[9]) begin
        qoe_r <= 4'hf;
        qo_r  <= bits_r[2] ? lsec[3:0] : lsec[7:4];
      end else begin
        qoe_r <= 4'h2;
        qo_r  <= {2'b00, lsec[3'h7 - bits_r], 1'b0};
      end
    end else begin
      qo_r  <= 4'h0;
      qoe_r <= 4'h0;
    end
  end
  assign QIO_O    = qo_r;
  assign QIO_OE_O = qoe_r;

  sec_read_a: assert property (@(negedge LINK_CLK_I) disable iff (CS_N_I || !RESET_N_I)
    QIO_OE_O != 4'h0 |-> lop_r == OP_SECRD && ltot_r != 3'h0)
    else $error("data lines driven outside a security read");

  // ---------------- core domain ----------------
  st_t          st_r;
  st_t          st_nxt;
  logic         cs_m_r;
  logic         cs_s_r;
  logic         cs_d_r;
  logic         end_p;
  logic [23:0]  tcnt_r;
  logic [7:0]   idx_r;
  logic         wel_r;
  logic         fail_r;
  logic         otp_lockdown_bit_r;
  logic         otp_r;
  logic         wip_r;
  logic [15:0]  page_r;
  logic         we_r;
  logic         aotp_r;
  logic [23:0]  aaddr_r;
  logic [7:0]   adata_r;
  logic         op_only;
  logic         is_pgm;
  logic         otp_lock;
  logic         cmd;
  logic         go_prog;
  logic         lock_rej;
  logic         prot_hit;
  logic         wake;
  logic         prog_done;

  // select edge crosses as a level; summary is stable once it is seen high
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
      cs_d_r <= 1'b1;
    end else begin
      cs_m_r <= CS_N_I;
      cs_s_r <= cs_m_r;
      cs_d_r <= cs_s_r;
    end
  end
  assign end_p = cs_s_r && !cs_d_r;

  always_comb begin
    op_only  = lalign_r && ltot_r == TOT_OP;
    is_pgm   = lalign_r && ltot_r == TOT_DATA && (lop_r == OP_PP ||
               (lop_r == OP_QPP && QUAD_ENABLE_I && !QUAD_MODE_I));
    otp_lock = otp_r && otp_lockdown_bit_r;
    cmd      = end_p && st_r == ST_IDLE && op_only;
    go_prog  = end_p && st_r == ST_IDLE && is_pgm && wel_r && !otp_lock;
    lock_rej = end_p && st_r == ST_IDLE && is_pgm && wel_r && otp_lock;
    prot_hit = !otp_r && (PROT_SELECT_I ? SOLID_PROT_I : BP_PROT_I);
    wake     = end_p && (st_r == ST_NAP || st_r == ST_SLEEP) && ltot_r != 3'h0 &&
               lop_r == OP_RDP;
    prog_done = st_r == ST_WAIT && tcnt_r == PROG_LAST;
  end

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (go_prog) begin
          st_nxt = ST_CHECK;
        end else if (cmd && lop_r == OP_DP) begin
          st_nxt = ST_NAP;
        end
      end
      ST_CHECK: st_nxt = prot_hit ? ST_IDLE : ST_WRITE;
      ST_WRITE: st_nxt = (idx_r == 8'hff) ? ST_WAIT : ST_WRITE;
      ST_WAIT:  st_nxt = prog_done ? ST_IDLE : ST_WAIT;
      ST_NAP: begin
        if (wake) begin
          st_nxt = ST_IDLE;
        end else if (tcnt_r == SLP_LAST) begin
          st_nxt = ST_SLEEP;
        end
      end
      ST_SLEEP: st_nxt = wake ? ST_IDLE : ST_SLEEP;
      default:  st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      st_r <= ST_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // one counter times both the program cycle and the sleep entry
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      tcnt_r <= 24'h000000;
      idx_r  <= 8'h00;
    end else begin
      tcnt_r <= (st_r == ST_IDLE || st_r == ST_SLEEP) ? 24'h000000 : tcnt_r + 24'h000001;
      idx_r  <= (st_r == ST_WRITE) ? idx_r + 8'h01 : 8'h00;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wel_r <= 1'b0;
    end else if (prog_done || (cmd && lop_r == OP_SECWR && wel_r && !otp_lock)) begin
      wel_r <= 1'b0;
    end else if (cmd && lop_r == OP_WRITE_ENABLE_CMD) begin
      wel_r <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      fail_r <= 1'b0;
    end else if ((st_r == ST_CHECK && prot_hit) || lock_rej) begin
      fail_r <= 1'b1;
    end else if (prog_done) begin
      fail_r <= 1'b0;
    end
  end

  // lock-down is one-way: nothing clears it but reset
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      otp_lockdown_bit_r <= 1'b0;
    end else if (cmd && lop_r == OP_SECWR && wel_r && !otp_lock) begin
      otp_lockdown_bit_r <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      otp_r <= 1'b0;
    end else if (cmd && lop_r == OP_OTPIN) begin
      otp_r <= 1'b1;
    end else if (cmd && lop_r == OP_OTPOUT) begin
      otp_r <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      wip_r   <= 1'b0;
      sleep_r <= 1'b0;
      sec_r   <= 8'h00;
    end else begin
      wip_r   <= st_nxt == ST_CHECK || st_nxt == ST_WRITE || st_nxt == ST_WAIT;
      sleep_r <= st_nxt == ST_SLEEP;
      sec_r   <= '0;
      sec_r[SEC_PSEL]  <= PROT_SELECT_I;
      sec_r[SEC_PFAIL] <= fail_r;
      sec_r[SEC_LOCK]  <= otp_lockdown_bit_r;
      sec_r[SEC_FACT]  <= FACTORY_LOCK;
    end
  end

  // page walk: one column per cycle, only columns that received data
  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      page_r  <= 16'h0000;
      we_r    <= 1'b0;
      aotp_r  <= 1'b0;
      aaddr_r <= 24'h000000;
      adata_r <= 8'h00;
    end else begin
      if (go_prog) begin
        page_r <= otp_r ? {15'h0000, laddr_r[8]} : laddr_r[23:8];
        aotp_r <= otp_r;
      end
      we_r    <= st_r == ST_WRITE && lmask_r[idx_r];
      aaddr_r <= {page_r, idx_r};
      adata_r <= lbuf[idx_r];
    end
  end

  assign WIP_O       = wip_r;
  assign WEL_O       = wel_r;
  assign PROG_FAIL_O = fail_r;
  assign LOCKDOWN_O  = otp_lockdown_bit_r;
  assign OTP_MODE_O  = otp_r;
  assign SLEEP_O     = sleep_r;
  assign PAGE_ADDR_O = page_r;
  assign ARR_WE_O    = we_r;
  assign ARR_OTP_O   = aotp_r;
  assign ARR_ADDR_O  = aaddr_r;
  assign ARR_DATA_O  = adata_r;

  sequence prog_start_s;
    st_r == ST_IDLE ##1 st_r == ST_CHECK;
  endsequence

  wel_needed_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    prog_start_s |-> $past(wel_r, 2))
    else $error("program started without write enable");
  prot_skip_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    st_r == ST_CHECK && prot_hit |=> st_r == ST_IDLE ##1 !ARR_WE_O [*3])
    else $error("protected page was written");
  wip_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    prog_start_s ##1 !prot_hit |-> ##1 WIP_O [*8])
    else $error("busy flag dropped during program");
  wip_wel_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    $fell(WIP_O) && !$past(prot_hit) |-> !WEL_O && !PROG_FAIL_O)
    else $error("latch or fail flag left set after program");
  page_wrap_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    ARR_WE_O |-> ARR_ADDR_O[23:8] == page_r && WIP_O)
    else $error("write left its page");
  nap_time_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    $rose(SLEEP_O) |-> $past(tcnt_r) == SLP_LAST)
    else $error("deep sleep entered at wrong delay");
  sleep_deaf_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    st_r == ST_SLEEP && !wake |=> st_r == ST_SLEEP && SLEEP_O)
    else $error("deep sleep left without release");
  otp_lock_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    ARR_WE_O && ARR_OTP_O |-> !otp_lockdown_bit_r)
    else $error("locked otp area written");
  lock_keep_a: assert property (@(posedge CORE_CLK_I) disable iff (!RESET_N_I)
    LOCKDOWN_O |=> LOCKDOWN_O)
    else $error("lock-down bit cleared");
endmodule
`default_nettype wire

// *** flash_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_host_model #(
  parameter int HALF_NS = 32
) (
  // link to the device
  output logic            sck_o,
  output logic            cs_n_o,
  output logic      [3:0] sio_o,
  input  wire logic [3:0] sio_i
);
  logic [15:0] rd_r;

  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    sio_o = 4'ha;
    rd_r = 16'h0;
  end

  // clock stands still outside frames; data is set a half period before the rising edge
  task automatic clk_bits(input logic [3:0] v);
    sio_o = v;
    #(HALF_NS) sck_o = 1'b1;
    rd_r = {rd_r[14:0], sio_i[1]};
    #(HALF_NS) sck_o = 1'b0;
  endtask

  task automatic put_byte(input logic [7:0] b, input logic q);
    if (q) begin
      clk_bits(b[7:4]);
      clk_bits(b[3:0]);
    end else begin
      // upper lines carry noise so a device that listens to them goes wrong
      for (int i = 7; i >= 0; i--) clk_bits({{3{~b[i]}}, b[i]});
    end
  endtask

  // opcode, opcode lanes, later lanes, address bytes, address, data bytes, seed, stray bits
  task automatic frame(input logic [7:0] op, input logic qo, input logic qr, input int na,
                       input logic [23:0] a, input int nd, input logic [7:0] s, input int xb);
    cs_n_o = 1'b0;
    #(HALF_NS);
    put_byte(op, qo);
    for (int i = 2; i >= 3 - na; i--) put_byte(a[8*i +: 8], qr);
    for (int k = 0; k < nd; k++) put_byte(s + 8'(k >> 1), qr);
    // stray bits are ones, so an undriven read line never passes for zero data
    for (int k = 0; k < xb; k++) clk_bits(4'hf);
    #(HALF_NS) cs_n_o = 1'b1;
    sio_o = ~sio_o; // released lines never hold the last bit
    #(HALF_NS * 2);
  endtask
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
  import flash_prog_pkg::*;
  localparam int PUS = 3;
  logic        core_clk = 1'b0, rst_n = 1'b0;
  logic        qmode = 1'b0, qen = 1'b0, psel = 1'b0, bp = 1'b0, solid = 1'b0;
  wire logic   sck, cs_n;
  wire logic [3:0] sio_h, sio_d, sio_oe, sio_w;
  wire logic   write_in_progress, write_enable_latch, pfail, lock, otp, sleep, we, arr_otp;
  wire logic [23:0] aadr;
  wire logic [7:0]  adat;
  wire logic [15:0] pg;
  int          n_fail = 0, check_count = 0;
  logic [7:0]  wdat [256];
  logic [23:0] wq [$];
  logic        wotp;

  always #5 core_clk = ~core_clk;
  assign sio_w = (sio_d & sio_oe) | (sio_h & ~sio_oe);

  flash_host_model #(.HALF_NS(32)) host_u (.sck_o(sck), .cs_n_o(cs_n), .sio_o(sio_h),
    .sio_i(sio_w));

  serial_flash_prog_ctrl #(.PROG_US(PUS), .SLEEP_US(1)) dut_u (.CORE_CLK_I(core_clk),
    .RESET_N_I(rst_n), .LINK_CLK_I(sck), .CS_N_I(cs_n), .QIO_I(sio_w), .QIO_O(sio_d),
    .QIO_OE_O(sio_oe), .QUAD_MODE_I(qmode), .QUAD_ENABLE_I(qen), .PROT_SELECT_I(psel),
    .BP_PROT_I(bp), .SOLID_PROT_I(solid), .WIP_O(write_in_progress), .WEL_O(write_enable_latch), .PROG_FAIL_O(pfail),
    .LOCKDOWN_O(lock), .OTP_MODE_O(otp), .SLEEP_O(sleep), .PAGE_ADDR_O(pg), .ARR_WE_O(we),
    .ARR_OTP_O(arr_otp), .ARR_ADDR_O(aadr), .ARR_DATA_O(adat));

  // array write monitor
  always @(posedge core_clk) begin
    if (we === 1'b1) begin
      wq.push_back(aadr);
      wdat[aadr[7:0]] = adat;
      wotp = arr_otp;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic settle;
    repeat (6) @(posedge core_clk);
  endtask

  task automatic do_reset;
    @(posedge core_clk);
    #1 rst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge core_clk);
  endtask

  task automatic cfg(input logic m, input logic e, input logic s, input logic b, input logic p);
    @(posedge core_clk);
    #1 {qmode, qen, psel, bp, solid} = {m, e, s, b, p};
    repeat (2) @(posedge core_clk);
    // a dummy frame lets the link side pick up a changed lane mode
    host_u.frame(8'h00, 1'b0, 1'b0, 0, 24'h0, 0, 8'h0, 0);
  endtask

  task automatic op_only(input logic [7:0] op, input logic q);
    host_u.frame(op, q, q, 0, 24'h0, 0, 8'h0, 0);
    settle;
  endtask

  task automatic prog(input logic [7:0] op, input logic qo, input logic qr,
                      input logic [23:0] a, input int nd, input logic [7:0] s);
    wq.delete();
    op_only(OP_WRITE_ENABLE_CMD, qo);
    host_u.frame(op, qo, qr, 3, a, nd, s, 0);
    settle;
  endtask

  // bounded wait for the end of the program cycle
  task automatic wait_idle;
    int n;
    n = 0;
    while (write_in_progress !== 1'b0 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20000) begin
      n_fail++;
      $display("MISMATCH wip_timeout expected 0 seen 1");
      complete_run;
    end
    settle;
  endtask

  task automatic sc_page_wrap;
    wq.delete();
    host_u.frame(OP_PP, 1'b0, 1'b0, 3, 24'h1234fe, 3, 8'h3c, 0);
    settle;
    check("no_latch_writes", wq.size(), 0);
    prog(OP_PP, 1'b0, 1'b0, 24'h1234fe, 3, 8'h3c);
    check("wip_busy", write_in_progress, 1);
    check("page_addr", pg, 16'h1234);
    host_u.frame(OP_SECRD, 1'b0, 1'b0, 0, 24'h0, 0, 8'h0, 16);
    check("secrd_busy", write_in_progress, 1);
    check("secrd_busy_data", host_u.rd_r, 16'h0000);
    wait_idle;
    check("status_after", {write_in_progress, write_enable_latch, pfail}, 3'b000);
    check("n_writes", wq.size(), 3);
    check("wrap_addr", wq[0], 24'h123400);
    check("first_addr", wq[1], 24'h1234fe);
    check("last_addr", wq[2], 24'h1234ff);
    check("wrap_data", wdat[8'h00], 8'h3d);
  endtask

  task automatic sc_overflow;
    prog(OP_PP, 1'b0, 1'b0, 24'h0a0b00, 258, 8'h40);
    wait_idle;
    check("ovf_writes", wq.size(), 256);
    check("ovf_col0", wdat[8'h00], 8'hc0);
    check("ovf_col2", wdat[8'h02], 8'h41);
  endtask

  task automatic sc_mid_byte;
    wq.delete();
    op_only(OP_WRITE_ENABLE_CMD, 1'b0);
    host_u.frame(OP_PP, 1'b0, 1'b0, 3, 24'h000010, 2, 8'h11, 3);
    settle;
    check("midbyte_writes", wq.size(), 0);
    check("midbyte_wip", {write_in_progress, write_enable_latch}, 2'b01);
  endtask

  task automatic sc_protect;
    logic [3:0] tbl [4] = '{4'b0101, 4'b0010, 4'b1100, 4'b1011};
    for (int i = 0; i < 4; i++) begin
      cfg(1'b0, 1'b0, tbl[i][3], tbl[i][2], tbl[i][1]);
      prog(OP_PP, 1'b0, 1'b0, 24'h200000, 1, 8'h77);
      wait_idle;
      check("prot_fail", pfail, tbl[i][0]);
      check("prot_writes", wq.size(), tbl[i][0] ? 0 : 1);
    end
  endtask

  task automatic sc_quad;
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    prog(OP_QPP, 1'b0, 1'b1, 24'h0055f0, 2, 8'ha6);
    wait_idle;
    check("qpp_no_qe", wq.size(), 0);
    cfg(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    prog(OP_QPP, 1'b0, 1'b1, 24'h0055f0, 2, 8'ha6);
    wait_idle;
    check("qpp_writes", wq.size(), 2);
    check("qpp_addr", wq[1], 24'h0055f1);
    check("qpp_data", wdat[8'hf0], 8'ha6);
    cfg(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    prog(OP_QPP, 1'b0, 1'b1, 24'h0055f0, 1, 8'ha6);
    wait_idle;
    check("qpp_prot", {pfail, 1'b0, wq.size() == 0}, 3'b101);
    cfg(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    prog(OP_QPP, 1'b1, 1'b1, 24'h003300, 1, 8'h5e);
    wait_idle;
    check("qpp_four_line", wq.size(), 0);
    prog(OP_PP, 1'b1, 1'b1, 24'h003300, 1, 8'h5e);
    wait_idle;
    check("pp_four_line", wdat[8'h00], 8'h5e);
    cfg(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
  endtask

  task automatic sc_otp;
    op_only(OP_OTPIN, 1'b0);
    check("otp_on", otp, 1);
    prog(OP_PP, 1'b0, 1'b0, 24'h000100, 1, 8'h9a);
    wait_idle;
    check("otp_write", {wq.size() == 1, wotp}, 2'b11);
    check("otp_page", pg, 16'h0001);
    op_only(OP_SECWR, 1'b0);
    check("secwr_no_latch", lock, 0);
    op_only(OP_WRITE_ENABLE_CMD, 1'b0);
    host_u.frame(OP_SECWR, 1'b0, 1'b0, 0, 24'h0, 0, 8'h0, 3);
    settle;
    check("secwr_midbyte", lock, 0);
    op_only(OP_SECWR, 1'b0);
    check("secwr_lock", {lock, write_enable_latch}, 2'b10);
    host_u.frame(OP_SECRD, 1'b0, 1'b0, 0, 24'h0, 0, 8'h0, 16);
    check("secrd_repeat", host_u.rd_r, 16'h0202);
    prog(OP_PP, 1'b0, 1'b0, 24'h000100, 1, 8'h00);
    wait_idle;
    check("otp_locked", {pfail, wq.size() == 0}, 2'b11);
    op_only(OP_OTPOUT, 1'b0);
    check("otp_off", otp, 0);
  endtask

  task automatic sc_sleep;
    // a clean program outside otp mode clears the latch and the fail flag left by the refusal
    prog(OP_PP, 1'b0, 1'b0, 24'h000200, 1, 8'h01);
    wait_idle;
    check("fail_cleared", pfail, 0);
    check("wel_clear", write_enable_latch, 0);
    host_u.frame(OP_DP, 1'b0, 1'b0, 0, 24'h0, 0, 8'h0, 8);
    repeat (150) @(posedge core_clk);
    check("dp_extra_byte", sleep, 0);
    op_only(OP_DP, 1'b0);
    repeat (74) @(posedge core_clk);
    check("dp_delay", sleep, 0);
    repeat (40) @(posedge core_clk);
    check("dp_asleep", sleep, 1);
    op_only(OP_WRITE_ENABLE_CMD, 1'b0);
    check("asleep_ignored", write_enable_latch, 0);
    op_only(OP_RDP, 1'b0);
    check("released", sleep, 0);
    op_only(OP_DP, 1'b0);
    repeat (120) @(posedge core_clk);
    do_reset;
    check("reset_wakes", {sleep, lock}, 2'b00);
  endtask

  initial begin
    do_reset;
    sc_page_wrap;
    sc_overflow;
    sc_mid_byte;
    sc_protect;
    sc_quad;
    sc_otp;
    sc_sleep;
    complete_run;
  end
endmodule
`default_nettype wire
